// ===== logic/mdfs_fault_sampler.v
// Registers a group of fault levels into the system clock domain.
// Assumes every source is synchronous to sys_clk.
module mdfs_fault_sampler #(
  parameter W = 17
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Fault levels
  input wire [W-1:0] raw,
  output wire [W-1:0] sampled
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg smp_r;
      always @(posedge sys_clk) begin
        if (rst) begin
          smp_r <= 1'b0;
        end else begin
          smp_r <= raw[i];
        end
      end
      assign sampled[i] = smp_r;
    end
  endgenerate
endmodule

// ===== logic/mdfs_fault_status.v
// Read-only fault status bank of a motor driver, reached over AXI4-Lite.
// Assumes fault sources are synchronous levels in the sys_clk domain.
`include "mdfs_regs.vh"

module mdfs_fault_status #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Power-stage fault sources
  input wire buck_regulator_fault,
  input wire overcurrent_flag,
  input wire supply_reset_detect,
  input wire supply_overvoltage_flag,
  input wire thermal_warning_flag,
  input wire thermal_shutdown_flag,
  input wire phase_c_high_overcurrent,
  input wire phase_c_low_overcurrent,
  input wire phase_b_high_overcurrent,
  input wire phase_b_low_overcurrent,
  input wire phase_a_high_overcurrent,
  input wire phase_a_low_overcurrent,
  input wire otp_error_flag,
  input wire regulator_overcurrent_flag,
  input wire regulator_undervoltage_flag,
  input wire charge_pump_undervoltage_flag,
  // Controller fault sources
  input wire position_detect_frequency_error,
  input wire position_detect_timer1_error,
  input wire rotor_lock_flag,
  input wire speed_loop_saturation_flag,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  localparam NSRC = 20;

  wire [NSRC-1:0] raw_faults;
  wire [NSRC-1:0] smp;

  // Listed from the top bit of smp down to bit 0.
  assign raw_faults = {
    speed_loop_saturation_flag,
    rotor_lock_flag,
    position_detect_timer1_error,
    position_detect_frequency_error,
    charge_pump_undervoltage_flag,
    regulator_undervoltage_flag,
    regulator_overcurrent_flag,
    otp_error_flag,
    phase_a_low_overcurrent,
    phase_a_high_overcurrent,
    phase_b_low_overcurrent,
    phase_b_high_overcurrent,
    phase_c_low_overcurrent,
    phase_c_high_overcurrent,
    thermal_shutdown_flag,
    thermal_warning_flag,
    supply_overvoltage_flag,
    supply_reset_detect,
    overcurrent_flag,
    buck_regulator_fault
  };

  // One flop per source brings every level into the sys_clk domain before use.
  mdfs_fault_sampler #(
    .W(NSRC)
  ) u_sampler (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw(raw_faults),
    .sampled(smp)
  );

  // Sampled sources by name.
  wire s_buck = smp[0];
  wire s_oc = smp[1];
  wire s_por = smp[2];
  wire s_ov = smp[3];
  wire s_otw = smp[4];
  wire s_tsd = smp[5];
  wire [5:0] s_sw = smp[11:6];
  wire s_otp = smp[12];
  wire s_reg_oc = smp[13];
  wire s_reg_uv = smp[14];
  wire s_cp_uv = smp[15];
  wire s_ipd_freq = smp[16];
  wire s_ipd_t1 = smp[17];
  wire s_lock = smp[18];
  wire s_spd_sat = smp[19];

  // Sources arrive C high first, but the register wants C high on its top bit.
  wire [5:0] sw_bits;
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_sw
      assign sw_bits[5-k] = s_sw[k];
    end
  endgenerate

  // Status register composition.
  reg [31:0] pwr_nxt;
  reg [31:0] ctl_nxt;
  reg [31:0] pwr_flags_r;
  reg [31:0] ctl_flags_r;

  always @* begin
    // Both words are rebuilt every cycle, so no flag is sticky.
    pwr_nxt = 32'h00000000;
    pwr_nxt[`MDFS_PWR_BUCK] = s_buck;
    pwr_nxt[`MDFS_PWR_OC] = s_oc | (|s_sw);
    pwr_nxt[`MDFS_PWR_SUPPLY_RESET_INVERTED_FLAG] = ~s_por;
    pwr_nxt[`MDFS_PWR_OV] = s_ov;
    pwr_nxt[`MDFS_PWR_OT] = s_otw | s_tsd;
    pwr_nxt[`MDFS_PWR_OTW] = s_otw;
    pwr_nxt[`MDFS_PWR_TSD] = s_tsd;
    pwr_nxt[`MDFS_PWR_SW_LO+5:`MDFS_PWR_SW_LO] = sw_bits;
    pwr_nxt[`MDFS_PWR_OTP] = s_otp;
    pwr_nxt[`MDFS_PWR_REG_OC] = s_reg_oc;
    pwr_nxt[`MDFS_PWR_REG_UV] = s_reg_uv;
    pwr_nxt[`MDFS_PWR_CP_UV] = s_cp_uv;
    // The inverted supply bit counts as a fault while it reads 0.
    pwr_nxt[`MDFS_PWR_SUMMARY] = s_buck | s_oc | (|s_sw) | s_por | s_ov | s_otw | s_tsd |
                                 s_otp | s_reg_oc | s_reg_uv | s_cp_uv;
    ctl_nxt = 32'h00000000;
    ctl_nxt[`MDFS_CTL_IPD_FREQ] = s_ipd_freq;
    ctl_nxt[`MDFS_CTL_IPD_T1] = s_ipd_t1;
    ctl_nxt[`MDFS_CTL_LOCK] = s_lock;
    ctl_nxt[`MDFS_CTL_SPD_SAT] = s_spd_sat;
    ctl_nxt[`MDFS_CTL_SUMMARY] = s_ipd_freq | s_ipd_t1 | s_lock | s_spd_sat;
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pwr_flags_r <= `MDFS_PWR_RESET;
      ctl_flags_r <= `MDFS_CTL_RESET;
    end else begin
      pwr_flags_r <= pwr_nxt;
      ctl_flags_r <= ctl_nxt;
    end
  end

  // Read channel: one read at a time, answered two cycles after arvalid is seen.
  localparam RD_IDLE = 2'b00;
  localparam RD_ADDR = 2'b01;
  localparam RD_RESP = 2'b10;

  reg [1:0] rd_state_r;
  reg [1:0] rd_state_nxt;
  reg arready_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [31:0] rd_word_nxt;
  reg [1:0] rd_resp_nxt;
  wire [ADDR_W-3:0] ar_idx = s_axi_araddr[ADDR_W-1:2];

  // Unmapped words read as zero with an error response.
  always @* begin
    rd_word_nxt = 32'h00000000;
    rd_resp_nxt = `MDFS_RESP_SLVERR;
    if (ar_idx == `MDFS_PWR_IDX) begin
      rd_word_nxt = pwr_flags_r;
      rd_resp_nxt = `MDFS_RESP_OKAY;
    end else if (ar_idx == `MDFS_CTL_IDX) begin
      rd_word_nxt = ctl_flags_r;
      rd_resp_nxt = `MDFS_RESP_OKAY;
    end
  end

  always @* begin
    rd_state_nxt = rd_state_r;
    case (rd_state_r)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          rd_state_nxt = RD_ADDR;
        end
      end
      RD_ADDR: begin
        // The address is taken here only if arvalid still stands.
        if (s_axi_arvalid) begin
          rd_state_nxt = RD_RESP;
        end else begin
          rd_state_nxt = RD_IDLE;
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          rd_state_nxt = RD_IDLE;
        end
      end
      default: begin
        rd_state_nxt = RD_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      rd_state_r <= RD_IDLE;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `MDFS_RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      arready_r <= (rd_state_nxt == RD_ADDR);
      rvalid_r <= (rd_state_nxt == RD_RESP);
      if (rd_state_r == RD_ADDR && s_axi_arvalid) begin
        rdata_r <= rd_word_nxt;
        rresp_r <= rd_resp_nxt;
      end
    end
  end

  // Write channels: address and data taken in either order, then one response.
  // A beat taken alone is parked until its partner arrives.
  reg awready_r;
  reg wready_r;
  reg aw_got_r;
  reg w_got_r;
  reg aw_hit_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  wire [ADDR_W-3:0] aw_idx = s_axi_awaddr[ADDR_W-1:2];
  wire aw_take = s_axi_awvalid && awready_r;
  wire w_take = s_axi_wvalid && wready_r;
  wire aw_done = aw_got_r || aw_take;
  wire w_done = w_got_r || w_take;
  wire aw_hit = (aw_idx == `MDFS_PWR_IDX) || (aw_idx == `MDFS_CTL_IDX);
  wire wr_ok = aw_take ? aw_hit : aw_hit_r;

  always @(posedge sys_clk) begin
    if (rst) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_hit_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `MDFS_RESP_OKAY;
    end else begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      if (s_axi_awvalid && !awready_r && !aw_got_r && !bvalid_r) begin
        awready_r <= 1'b1;
      end
      if (s_axi_wvalid && !wready_r && !w_got_r && !bvalid_r) begin
        wready_r <= 1'b1;
      end
      if (aw_take) begin
        aw_hit_r <= aw_hit;
      end
      if (aw_done && w_done) begin
        // Both registers are read-only: the data is dropped.
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        if (wr_ok) begin
          bresp_r <= `MDFS_RESP_OKAY;
        end else begin
          bresp_r <= `MDFS_RESP_SLVERR;
        end
      end else begin
        aw_got_r <= aw_done;
        w_got_r <= w_done;
        if (bvalid_r && s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // Every bus output is driven straight from its flip-flop.
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

endmodule

// ===== logic/mdfs_regs.vh
// Register map, field positions and bus codes of the motor driver fault status bank.
// Assumes inclusion by plain Verilog-2005 design files; definitions only.
//
// What this block does
// - Power bit 30 flags buck regulator fault.
// - Power bit 28 flags overcurrent or any per-switch overcurrent, not regulator overcurrent.
// - Power bit 27 low on supply reset.
// - Power bit 26 flags supply overvoltage.
// - Power bit 25 flags thermal warning or shutdown.
// - Power bit 23 flags thermal warning.
// - Power bit 22 flags thermal shutdown.
// - Power bits 21..16 flag per-switch overcurrent.
// - Power bit 14 flags programmable memory error.
// - Power bit 13 flags regulator overcurrent.
// - Power bit 12 flags regulator undervoltage.
// - Power bit 11 flags charge pump undervoltage.
// - Controller bit 31 ORs all controller faults.
// - Controller bit 29 flags position-detect frequency error.
// - Controller bit 28 flags position-detect timer error.
// - Controller register E2h, read-only, resets zero.
// - Power bit 31 ORs all power faults.
// - Controller bit 20 flags rotor lock.
// - Controller bit 15 flags speed loop saturation.
`ifndef MDFS_REGS_VH
`define MDFS_REGS_VH

// Register indices; the byte address is four times the index.
`define MDFS_PWR_IDX 10'h0E0
`define MDFS_CTL_IDX 10'h0E2
`define MDFS_PWR_RESET 32'h00000000
`define MDFS_CTL_RESET 32'h00000000

// Power-stage fault register fields.
`define MDFS_PWR_SUMMARY 31
`define MDFS_PWR_BUCK 30
`define MDFS_PWR_OC 28
`define MDFS_PWR_SUPPLY_RESET_INVERTED_FLAG 27
`define MDFS_PWR_OV 26
`define MDFS_PWR_OT 25
`define MDFS_PWR_OTW 23
`define MDFS_PWR_TSD 22
`define MDFS_PWR_SW_LO 16
`define MDFS_PWR_OTP 14
`define MDFS_PWR_REG_OC 13
`define MDFS_PWR_REG_UV 12
`define MDFS_PWR_CP_UV 11

// Controller fault register fields.
`define MDFS_CTL_SUMMARY 31
`define MDFS_CTL_IPD_FREQ 29
`define MDFS_CTL_IPD_T1 28
`define MDFS_CTL_LOCK 20
`define MDFS_CTL_SPD_SAT 15

// AXI response codes.
`define MDFS_RESP_OKAY 2'h0
`define MDFS_RESP_SLVERR 2'h2

`endif

// ===== sim/mdfs_fault_status_sva.sv
// Checker for the fault status bank: bus answers and the shape of each read word.
// Assumes it is bound to mdfs_fault_status and sees only that module's ports.
`include "mdfs_regs.vh"
module mdfs_fault_status_sva #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Read channels
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Write channels
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [ADDR_W-1:0] ra_r;
  wire [31:0] d = s_axi_rdata;
  wire ok = s_axi_rvalid && s_axi_rresp == `MDFS_RESP_OKAY;
  wire pw = ok && ra_r[ADDR_W-1:2] == `MDFS_PWR_IDX;
  wire cw = ok && ra_r[ADDR_W-1:2] == `MDFS_CTL_IDX;
  // Remembers which word the pending read answer belongs to.
  always @(posedge sys_clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_r <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(d))
    else $error("read answer not held");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer missing");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_UNMAPPED: assert property (s_axi_rvalid && s_axi_rresp != `MDFS_RESP_OKAY
    |-> d == 0)
    else $error("unmapped read not zero");
  AST_PWR_RSV: assert property (pw |-> !d[29] && !d[24] && !d[15] && d[10:0] == 0)
    else $error("power reserved bit set");
  AST_CTL_RSV: assert property (cw |-> {d[30], d[27:21], d[19:16], d[14:0]} == 0)
    else $error("controller reserved bit set");
  AST_PWR_SUM: assert property (pw |-> d[31] == |{d[30:28], ~d[27], d[26:11]})
    else $error("power summary wrong");
  AST_CTL_SUM: assert property (cw |-> d[31] == |d[30:0])
    else $error("controller summary wrong");
  AST_THERMAL: assert property (pw |-> d[25] == (d[23] | d[22]))
    else $error("thermal summary wrong");
  AST_OC_SUM: assert property (pw && |d[21:16] |-> d[28])
    else $error("overcurrent summary wrong");
endmodule

bind mdfs_fault_status mdfs_fault_status_sva #(.ADDR_W(ADDR_W)) u_sva (
  .sys_clk(sys_clk),
  .rst(rst),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready)
);

// ===== sim/mdfs_fault_status_tb.sv
// Bench for the fault status bank: fault levels set, then both words read over AXI4-Lite.
// Assumes the checker is bound separately; expected words queue up for a monitor.
`include "mdfs_regs.vh"
module mdfs_fault_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] pwr_a = {`MDFS_PWR_IDX, 2'b00};
  localparam logic [11:0] ctl_a = {`MDFS_CTL_IDX, 2'b00};
  localparam logic [11:0] gap_a = 12'h384;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] f = 20'h00000;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int fails = 0;
  int n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  mdfs_fault_status dut (.sys_clk(sys_clk), .rst(rst),
    .buck_regulator_fault(f[0]), .overcurrent_flag(f[1]), .supply_reset_detect(f[2]),
    .supply_overvoltage_flag(f[3]), .thermal_warning_flag(f[4]), .thermal_shutdown_flag(f[5]),
    .phase_a_low_overcurrent(f[6]), .phase_a_high_overcurrent(f[7]),
    .phase_b_low_overcurrent(f[8]), .phase_b_high_overcurrent(f[9]),
    .phase_c_low_overcurrent(f[10]), .phase_c_high_overcurrent(f[11]),
    .charge_pump_undervoltage_flag(f[12]), .regulator_undervoltage_flag(f[13]),
    .regulator_overcurrent_flag(f[14]), .otp_error_flag(f[15]),
    .speed_loop_saturation_flag(f[16]), .rotor_lock_flag(f[17]),
    .position_detect_timer1_error(f[18]), .position_detect_frequency_error(f[19]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  function automatic logic [31:0] pexp(input logic [19:0] v);
    return {|v[15:0], v[0], 1'b0, v[1] | (|v[11:6]), ~v[2], v[3], v[4] | v[5], 1'b0,
      v[4], v[5], v[11:6], 1'b0, v[15:12], 11'h000};
  endfunction
  function automatic logic [31:0] cexp(input logic [19:0] v);
    return {|v[19:16], 1'b0, v[19], v[18], 7'h00, v[17], 4'h0, v[16], 15'h0000};
  endfunction
  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [1:0] e);
    bit ad = 1'b0;
    bit wd = 1'b0;
    bq.push_back(e);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= $urandom;
    wstrb <= 4'($urandom);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  // Sets the fault levels, lets them reach the status words, then reads both.
  task automatic look(input logic [19:0] v);
    f <= v;
    repeat (3) @(posedge sys_clk);
    rd(pwr_a,
      {`MDFS_RESP_OKAY, pexp(v)});
    rd(ctl_a, {`MDFS_RESP_OKAY, cexp(v)});
  endtask
  always @(posedge sys_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("read", {rresp, rdata}, rq.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(62));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    look(20'h00000);
    for (int i = 0; i < 20; i++) look(20'h00001 << i);
    repeat (30) look(20'($urandom));
    f <= 20'hFFFFF;
    wr(pwr_a, `MDFS_RESP_OKAY);
    wr(ctl_a, `MDFS_RESP_OKAY);
    wr(gap_a, `MDFS_RESP_SLVERR);
    look(20'hFFFFF);
    rd(gap_a, {`MDFS_RESP_SLVERR, 32'h00000000});
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    look(20'($urandom));
    // Lets the monitor take the last answer before the queues are checked.
    @(posedge sys_clk);
    chk("pending", 34'(rq.size() + bq.size()), 34'h0);
    summarize();
  end
endmodule
